//--- dv/sss_master.sv
// Bus master model driving the slice's inputs one operation at a time.
// Assumes the bench clock; inputs change only at rising edges.
`timescale 1ns/10ps
module sss_master (
    input  wire logic        clk_sys_in,    // System clock
    output logic [2:0]       cs_out,        // Primary_n, depth_high, depth_low_n
    output logic [1:0]       strobe_n_out,  // Processor and controller strobes
    output logic             gw_n_out,      // Global write
    output logic             gate_n_out,    // Byte write gate
    output logic [3:0]       lane_n_out,    // Lane selects
    output logic [3:0]       addr_out,      // Word address
    output logic [31:0]      wdata_out,     // Write data
    output logic             sleep_out      // Sleep request
);
    // Quiet bus at time zero: deselected, no strobe, no write
    initial begin
        {cs_out, strobe_n_out, gw_n_out, gate_n_out, lane_n_out} = 11'h4FF;
        {addr_out, wdata_out, sleep_out} = 37'h0;
    end
    // One operation: drive at an edge, release strobes and writes at the sampling edge
    task automatic cyc(input logic [2:0] cs, input logic [1:0] st, input logic gw,
                       input logic gt, input logic [3:0] ln, input logic [3:0] a,
                       input logic [31:0] d, input logic zz);
        @(posedge clk_sys_in);
        cs_out <= cs;
        strobe_n_out <= st;
        {gw_n_out, gate_n_out, lane_n_out} <= {gw, gt, ln};
        {addr_out, wdata_out} <= {a, d};
        sleep_out <= zz & (cs != 3'h2);
        @(posedge clk_sys_in);
        strobe_n_out <= 2'h3;                  // One-cycle strobe
        {gw_n_out, gate_n_out} <= 2'h3;        // One-cycle write
        #1;
    endtask
endmodule

//--- dv/sync_sram_select_write_sleep_tb_top.sv
// Self-checking bench for the select, write, read drive and sleep slice.
// Assumes sss_core and the sss_master model; clock enable held high.
`timescale 1ns/10ps
module sync_sram_select_write_sleep_tb_top;
    import sss_pkg::*;
    typedef struct packed {
        logic [2:0] cs; logic [1:0] st; logic gw; logic gt; logic [3:0] ln;
        logic [3:0] a; logic [31:0] d; logic oe; logic [31:0] q; logic sel;
    } sss_row_s;
    logic clk_sys_in, rst_n_in, gw, gt, zz, dq_oe_out, selected_out, sleeping_out;
    logic [2:0] cs;
    logic [1:0] st;
    logic [3:0] ln, a;
    logic [31:0] d, dq_out;
    int errors = 0;
    int checks = 0;
    sss_row_s rows [12] = '{
        '{3'h2, 2'h3, 1'h0, 1'h1, 4'hF, 4'h1, 32'hAABB_CCDD, 1'h0, 32'h0, 1'h1},
        '{3'h2, 2'h1, 1'h1, 1'h1, 4'hF, 4'h1, 32'h0, 1'h1, 32'hAABB_CCDD, 1'h1},
        '{3'h2, 2'h3, 1'h1, 1'h0, 4'h0, 4'h2, 32'h1122_3344, 1'h0, 32'h0, 1'h1},
        '{3'h2, 2'h2, 1'h1, 1'h1, 4'hF, 4'h2, 32'h0, 1'h1, 32'h1122_3344, 1'h1},
        '{3'h2, 2'h3, 1'h1, 1'h0, 4'hA, 4'h2, 32'h5566_7788, 1'h0, 32'h0, 1'h1},
        '{3'h2, 2'h3, 1'h1, 1'h1, 4'h0, 4'h2, 32'h0, 1'h0, 32'h0, 1'h1},
        '{3'h2, 2'h1, 1'h1, 1'h1, 4'hF, 4'h2, 32'h0, 1'h1, 32'h1166_3388, 1'h1},
        '{3'h6, 2'h3, 1'h0, 1'h1, 4'hF, 4'h2, 32'h0, 1'h1, 32'h1166_3388, 1'h0},
        '{3'h0, 2'h1, 1'h1, 1'h1, 4'hF, 4'h2, 32'h0, 1'h0, 32'h0, 1'h0},
        '{3'h2, 2'h1, 1'h1, 1'h1, 4'hF, 4'h2, 32'h0, 1'h1, 32'h1166_3388, 1'h1},
        '{3'h3, 2'h2, 1'h1, 1'h1, 4'hF, 4'h2, 32'h0, 1'h0, 32'h0, 1'h0},
        '{3'h2, 2'h1, 1'h1, 1'h1, 4'hF, 4'h2, 32'h0, 1'h1, 32'h1166_3388, 1'h1}};
    sss_master m (.clk_sys_in(clk_sys_in), .cs_out(cs), .strobe_n_out(st), .gw_n_out(gw),
        .gate_n_out(gt), .lane_n_out(ln), .addr_out(a), .wdata_out(d), .sleep_out(zz));
    sss_core DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .chip_select_primary_n_in(cs[2]), .chip_select_depth_high_in(cs[1]),
        .chip_select_depth_low_n_in(cs[0]), .processor_address_strobe_n_in(st[0]),
        .controller_address_strobe_n_in(st[1]), .global_write_n_in(gw),
        .byte_write_gate_n_in(gt), .byte_lane_write_n_in(ln), .addr_in(a), .dq_in(d),
        .sleep_request_in(zz), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
        .selected_out(selected_out), .sleeping_out(sleeping_out));
    task automatic chk1(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Free-running 50 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // Watchdog cuts a hang short
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
    // Reset, table rows, sleep entry and exit, then a mid-run reset
    initial begin
        rst_n_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        #1;
        chk1(dq_oe_out, 1'b0, "reset drive");
        chk1(sleeping_out, 1'b0, "reset sleep");
        chkw(dq_out, DATA_RST, "reset data");
        $display("test reset done");
        foreach (rows[i]) begin
            m.cyc(rows[i].cs, rows[i].st, rows[i].gw, rows[i].gt, rows[i].ln, rows[i].a,
                  rows[i].d, 1'b0);
            chk1(selected_out, rows[i].sel, "select");
            chk1(dq_oe_out, rows[i].oe, "drive");
            if (rows[i].oe) chkw(dq_out, rows[i].q, "read data");
        end
        $display("test table done");
        m.cyc(3'h6, 2'h3, 1'b1, 1'b1, 4'hF, 4'h2, 32'h0, 1'b1);
        chk1(sleeping_out, 1'b1, "sleep entry");
        // Exit with a strobe present; pins must still stay off
        m.cyc(3'h2, 2'h1, 1'b1, 1'b1, 4'hF, 4'h2, 32'h0, 1'b0);
        chk1(sleeping_out, 1'b0, "sleep exit");
        chk1(dq_oe_out, 1'b0, "drive on exit");
        $display("test sleep done");
        // Reset during a read drops the drive and keeps the array
        m.cyc(3'h2, 2'h1, 1'b1, 1'b1, 4'hF, 4'h2, 32'h0, 1'b0);
        chk1(dq_oe_out, 1'b1, "read before reset");
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        #1;
        chk1(dq_oe_out, 1'b0, "mid reset drive");
        chkw(dq_out, DATA_RST, "mid reset data");
        m.cyc(3'h2, 2'h1, 1'b1, 1'b1, 4'hF, 4'h2, 32'h0, 1'b0);
        chkw(dq_out, 32'h1166_3388, "array kept over reset");
        $display("test mid reset done");
        print_verdict();
    end
endmodule

//--- inc/sss_pkg.sv
// Shared constants for the synchronous SRAM select, write and sleep slice.
// Assumes a single rising-edge clock domain and a small internal array.
package sss_pkg;
    // -------------------------------------------------------------------
    // Geometry
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W  = 4;                 // Word address width
    localparam int unsigned LANES   = 4;                 // Byte lanes per word
    localparam int unsigned LANE_W  = 8;                 // Bits per lane
    localparam int unsigned DATA_W  = LANES * LANE_W;    // Word width
    localparam int unsigned DEPTH   = 1 << ADDR_W;       // Words held
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
    // -------------------------------------------------------------------
    // Output phase states
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        SSS_IDLE  = 3'b001,                              // Outputs high-Z
        SSS_READ  = 3'b010,                              // Read data driven
        SSS_SLEEP = 3'b100                               // Low-power sleep
    } sss_state_e;
endpackage

//--- rtl/sss_core.sv
// Select decode, byte-lane writes, read output drive and sleep control.
// Assumes all inputs are synchronous to clk_sys_in and the master keeps its own timing.
`timescale 1ns/10ps

module sss_core (
    input  wire logic                        clk_sys_in,                  // System clock
    input  wire logic                        rst_n_in,                    // Sync reset, low
    input  wire logic                        clk_en_in,                   // Freezes state when low
    input  wire logic                        chip_select_primary_n_in,    // Primary enable
    input  wire logic                        chip_select_depth_high_in,   // Second enable
    input  wire logic                        chip_select_depth_low_n_in,  // Third enable
    input  wire logic                        processor_address_strobe_n_in, // Proc strobe
    input  wire logic                        controller_address_strobe_n_in, // Ctrl strobe
    input  wire logic                        global_write_n_in,           // Global write
    input  wire logic                        byte_write_gate_n_in,        // Byte write gate
    input  wire logic [sss_pkg::LANES-1:0]   byte_lane_write_n_in,        // Lane selects
    input  wire logic [sss_pkg::ADDR_W-1:0]  addr_in,                     // Word address
    input  wire logic [sss_pkg::DATA_W-1:0]  dq_in,                       // Data pin input
    input  wire logic                        sleep_request_in,            // Sleep request
    output logic      [sss_pkg::DATA_W-1:0]  dq_out,                      // Data pin output
    output logic                             dq_oe_out,                   // Data pin drive
    output logic                             selected_out,                // Select decode
    output logic                             sleeping_out                 // In sleep mode
);
    import sss_pkg::*;

    // -------------------------------------------------------------------
    // State record
    // -------------------------------------------------------------------
    typedef struct packed {
        sss_state_e               state;
        logic [DATA_W-1:0]        q;
        logic [ADDR_W-1:0]        addr;
    } sss_s;

    sss_s              st_r;
    sss_s              st_nxt;
    logic [DATA_W-1:0] mem_r [DEPTH];
    logic              sel;
    logic              strobe;
    logic              write_cyc;
    logic [LANES-1:0]  lane_we;
    logic              read_go;
    logic              sleep_go;

    // -------------------------------------------------------------------
    // Input decode
    // -------------------------------------------------------------------
    // Chip select decode; any one failing enable deselects
    assign sel    = !chip_select_primary_n_in && chip_select_depth_high_in
                    && !chip_select_depth_low_n_in;
    // Either address strobe opens a new access
    assign strobe = !processor_address_strobe_n_in || !controller_address_strobe_n_in;

    // -------------------------------------------------------------------
    // Write path
    // -------------------------------------------------------------------
    // Write lane decode; a write needs a selected, awake device
    assign write_cyc = sel && (st_r.state != SSS_SLEEP) && !sleep_request_in &&
                       (!global_write_n_in || !byte_write_gate_n_in);
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            // Global write covers all lanes, else lane select applies
            assign lane_we[gi] = write_cyc &&
                (!global_write_n_in || !byte_lane_write_n_in[gi]);
        end
    endgenerate

    // A read starts on a strobe to a selected device with no write pending
    assign read_go  = strobe && sel && !write_cyc;
    // Sleep is honoured only once the master has deselected the device
    assign sleep_go = sleep_request_in && !sel;

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            // Outputs off; wait for sleep or a read strobe
            SSS_IDLE: begin
                if (sleep_go) begin
                    st_nxt.state = SSS_SLEEP;
                end else if (read_go) begin
                    st_nxt.state = SSS_READ;
                    st_nxt.addr  = addr_in;
                end
            end
            // Pins driven; a write or deselect strobe turns them off
            SSS_READ: begin
                if (write_cyc) begin
                    st_nxt.state = SSS_IDLE;
                end else if (sleep_go) begin
                    st_nxt.state = SSS_SLEEP;
                end else if (strobe && !sel) begin
                    st_nxt.state = SSS_IDLE;
                end else if (strobe) begin
                    st_nxt.addr  = addr_in;
                end
            end
            // Strobes ignored; exit lands in the idle, undriven state
            SSS_SLEEP: begin
                if (!sleep_request_in) begin
                    st_nxt.state = SSS_IDLE;
                end
            end
            // Stray codes fall back to the undriven state
            default: begin
                st_nxt.state = SSS_IDLE;
            end
        endcase
        // Read data follows the array at the held address
        st_nxt.q = mem_r[st_nxt.addr];
    end

    // -------------------------------------------------------------------
    // Registers and array
    // -------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            st_r <= '{state: SSS_IDLE, q: DATA_RST, addr: ADDR_RST};
        end else if (clk_en_in) begin
            st_r <= st_nxt;
            // Lanes land independently; unselected lanes keep contents
            for (int i = 0; i < LANES; i++) begin
                if (lane_we[i]) begin
                    mem_r[addr_in][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Pin and status outputs
    // -------------------------------------------------------------------
    // Pin drive only while a read is active
    assign dq_out       = st_r.q;
    assign dq_oe_out    = (st_r.state == SSS_READ);
    assign selected_out = sel;
    assign sleeping_out = (st_r.state == SSS_SLEEP);

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    // Strobe while deselected never leaves the pins driven
    AST_SEL_DECODE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (clk_en_in && strobe && !sel) |=> !dq_oe_out)
        else $error("read started while deselected");

    // Deselected or idle write controls touch no lane
    AST_NO_WRITE_IDLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!sel || (global_write_n_in && byte_write_gate_n_in)) |-> lane_we == '0)
        else $error("lane written without a write request");

    // Full-width write reaches every lane
    AST_FULL_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (write_cyc && (!global_write_n_in || byte_lane_write_n_in == '0))
        |-> lane_we == '1)
        else $error("full write missed lanes");

    // Read data matches the array word at the strobed address
    AST_READ_DATA: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (clk_en_in && read_go && !sleeping_out) |=> dq_out == mem_r[$past(addr_in)])
        else $error("read data differs from stored word");

    // Pins go undriven after a write
    AST_WRITE_HIZ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (clk_en_in && write_cyc) |=> !dq_oe_out)
        else $error("outputs driven after write");

    // Read drive stands while nothing ends it
    AST_READ_STANDS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (clk_en_in && dq_oe_out && !strobe && !write_cyc && !sleep_request_in)
        |=> dq_oe_out)
        else $error("read drive dropped early");

    // Undriven pins stay undriven without a strobe
    AST_READ_NEEDS_STROBE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!dq_oe_out && !(clk_en_in && strobe)) |=> !dq_oe_out)
        else $error("read started without strobe");

    // A valid strobe turns the pins on next cycle
    AST_STROBE_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (clk_en_in && read_go && !sleeping_out) |=> dq_oe_out)
        else $error("strobed read did not drive");

    // Sleep entered only from a deselected device
    AST_SLEEP_DESEL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(sleeping_out) |-> !$past(sel))
        else $error("sleep entered while selected");

    // Pins stay off on wake until a fresh strobe
    AST_WAKE_HIZ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $fell(sleeping_out) |-> !dq_oe_out ##1 (!dq_oe_out || $past(strobe)))
        else $error("data driven on wake");

    // Dropping the request wakes into the undriven state
    AST_WAKE_IDLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (clk_en_in && sleeping_out && !sleep_request_in) |=> !sleeping_out && !dq_oe_out)
        else $error("wake left pins driven");

    // Partial write follows the lane selects
    AST_LANE_MASK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (global_write_n_in && write_cyc) |-> lane_we == ~byte_lane_write_n_in)
        else $error("lane mask wrong");

    // Held request keeps the device asleep, quiet and unwritten
    AST_SLEEP_NO_DRIVE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (clk_en_in && sleeping_out && sleep_request_in)
        |-> lane_we == '0 ##1 (sleeping_out && !dq_oe_out))
        else $error("activity during sleep");

endmodule
